//--- verilog/mft_pkg.sv
/*
 * mft_pkg: constants of the timer flag, mask and output-b block.
 * assumes apb with 32-bit data; registers sit at word index * 4.
 */
package mft_pkg;
   // ********************************************
   // register indices (byte address = index * 4)
   // ********************************************
   localparam logic [7:0] IDX_PTR = 8'hf0;
   localparam logic [7:0] IDX_OBC = 8'hfd;
   localparam logic [7:0] IDX_FLAGS = 8'hfe;
   localparam logic [7:0] IDX_MASK = 8'hff;
   localparam int ADDR_W = 10;

   // ********************************************
   // reset values
   // ********************************************
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_OBC = 8'h00;
   localparam logic [7:0] RST_PTR = 8'h00;

   // ********************************************
   // flag register bits
   // ********************************************
   localparam int B_CAP0 = 7;
   localparam int B_CAP1 = 6;
   localparam int B_CMP0 = 5;
   localparam int B_CMP1 = 4;
   localparam int B_WRAP = 3;
   localparam int B_CAP0_OVR = 2;
   localparam int B_CMP0_OVR = 1;
   localparam int B_SEL = 0;

   // ********************************************
   // mask register bits
   // ********************************************
   localparam int B_GIE = 7;
   localparam int B_CAP0_DMA = 6;
   localparam int B_CAP0_IRQ = 5;
   localparam int B_CAP1_IRQ = 4;
   localparam int B_CMP0_DMA = 3;
   localparam int B_CMP0_IRQ = 2;
   localparam int B_CMP1_IRQ = 1;
   localparam int B_WRAP_IRQ = 0;

   // ********************************************
   // output-b control and pointer bits
   // ********************************************
   localparam int B_EVT_EN = 1;
   localparam int B_PRE = 0;
   localparam int B_PTR_TGL = 2;
   localparam int B_DIR = 1;
   localparam int B_AREA = 0;
   localparam int NSRC = 3;

   // action codes as {e0, e1}: e0 is the upper bit of each field
   localparam logic [1:0] ACT_SET = 2'h0;
   localparam logic [1:0] ACT_TGL = 2'h1;
   localparam logic [1:0] ACT_CLR = 2'h2;
   localparam logic [1:0] ACT_NOP = 2'h3;
endpackage

//--- verilog/mft_ob_if.sv
/*
 * mft_ob_if: output-b events and action codes between the flag block
 * and the merge unit. assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface mft_ob_if;
   logic [mft_pkg::NSRC-1:0] evt;
   logic [mft_pkg::NSRC-1:0][1:0] code;
   logic [1:0] merged;
   logic any;
   modport src (output evt, output code, input merged, input any);
   modport merge (input evt, input code, output merged, output any);
endinterface

//--- verilog/mft_ob_merge.sv
/*
 * mft_ob_merge: merges the action codes of coincident output-b events.
 * assumes codes are stable while their events are high.
 */
`timescale 1ns/1ps
module mft_ob_merge (
   mft_ob_if.merge ob
);
   logic [mft_pkg::NSRC-1:0] t0;
   logic [mft_pkg::NSRC-1:0] t1;

   // R2 bitwise and merge
   // an idle source passes ones so it never masks the others
   genvar i;
   generate
      for (i = 0; i < mft_pkg::NSRC; i++) begin : g_src
         assign t0[i] = ~ob.evt[i] | ob.code[i][0];
         assign t1[i] = ~ob.evt[i] | ob.code[i][1];
      end
   endgenerate

   assign ob.merged = {&t1, &t0};
   assign ob.any = |ob.evt;
endmodule

//--- verilog/mft_flags_irq_dma.sv
/*
 * mft_flags_irq_dma: event flags, interrupt and dma masks, dma counter
 * pointer and output-b pin of a 16-bit multifunction timer, on apb.
 * assumes event inputs are one-cycle pulses synchronous to pclk.
 */
// Function
// R1 - two-bit code sets, toggles, clears, holds pin
// R2 - coincident events and their code bits
// R3 - overflow pulses on-chip event when enabled
// R4 - preset bit writes pin, reads pin level
// R5 - capture0 flag; write one soft captures
// R6 - capture1 flag; soft capture unless bicapture
// R7 - combine bit ors or ands capture flags
// R8 - compare0 flag interrupts with global, mask
// R9 - compare1 flag interrupts with global, mask
// R10 - overflow flag interrupts with global, mask
// R11 - capture0 overrun on repeat or soft capture
// R12 - compare0 overrun on repeat request
// R13 - global enable gates all interrupts
// R14 - capture0 dma enable cleared at block end
// R15 - capture0 mask covers end-of-block in dma
// R16 - compare0 dma enable cleared at block end
// R17 - compare0 mask covers end-of-block in dma
// R18 - own masks for capture1, compare1, overflow
// R19 - pointer high bits; bit2 toggles in swap
// R20 - hardware direction bit: capture or compare
// R21 - bit0 selects memory or register file
// R22 - hardware set beats software clear
`timescale 1ns/1ps
module mft_flags_irq_dma (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mft_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture0_evt,
   input wire logic capture1_evt,
   input wire logic compare0_evt,
   input wire logic compare1_evt,
   input wire logic overflow_evt,
   input wire logic bicapture_mode,
   input wire logic capture0_eob,
   input wire logic compare0_eob,
   input wire logic compare0_swap_step,
   output logic timer_output_b_pin,
   output logic on_chip_event,
   output logic sw_capture0_pulse,
   output logic sw_capture1_pulse,
   output logic capture0_dma_req,
   output logic compare0_dma_req,
   output logic irq_capture,
   output logic irq_compare,
   output logic irq_overflow
);
   // ********************************************
   // apb decode
   // ********************************************
   logic setup, wr, hit_any;
   logic hit_ptr, hit_obc, hit_flg, hit_msk;
   logic wr_ptr, wr_obc, wr_flg, wr_msk;
   logic [7:0] wb;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign wb = pwdata[7:0];
   assign hit_ptr = paddr == {mft_pkg::IDX_PTR, 2'h0};
   assign hit_obc = paddr == {mft_pkg::IDX_OBC, 2'h0};
   assign hit_flg = paddr == {mft_pkg::IDX_FLAGS, 2'h0};
   assign hit_msk = paddr == {mft_pkg::IDX_MASK, 2'h0};
   assign hit_any = hit_ptr | hit_obc | hit_flg | hit_msk;
   assign wr_ptr = wr & hit_ptr;
   assign wr_obc = wr & hit_obc;
   assign wr_flg = wr & hit_flg;
   assign wr_msk = wr & hit_msk;
   // every access completes in its first access cycle
   assign pready = 1'b1;

   // ********************************************
   // registers
   // ********************************************
   logic [7:0] flags, mask, ptr;
   logic [7:1] obc, fset, fclr;
   logic sw_cap0, sw_cap1;

   assign sw_cap0 = wr_flg & wb[mft_pkg::B_CAP0];
   assign sw_cap1 = wr_flg & wb[mft_pkg::B_CAP1] & ~bicapture_mode;

   // R5 capture0 set sources
   // R15 while dma runs a capture feeds dma; the flag waits for block end
   assign fset[mft_pkg::B_CAP0] = (capture0_evt & ~mask[mft_pkg::B_CAP0_DMA]) | capture0_eob | sw_cap0;
   // R6 capture1 set sources
   assign fset[mft_pkg::B_CAP1] = capture1_evt | sw_cap1;
   // R17 compare0 flag waits for block end
   assign fset[mft_pkg::B_CMP0] = (compare0_evt & ~mask[mft_pkg::B_CMP0_DMA]) | compare0_eob;
   // R9 compare1 match
   assign fset[mft_pkg::B_CMP1] = compare1_evt;
   // R10 counter wrap
   assign fset[mft_pkg::B_WRAP] = overflow_evt;
   // R11 repeat capture or soft capture
   assign fset[mft_pkg::B_CAP0_OVR] = (capture0_evt & flags[mft_pkg::B_CAP0]) | sw_cap0;
   // R12 repeat compare request
   assign fset[mft_pkg::B_CMP0_OVR] = compare0_evt & flags[mft_pkg::B_CMP0];

   // R22 set beats clear
   // a flag is cleared by writing zero to it; writing one never clears
   genvar i;
   generate
      for (i = 1; i < 8; i++) begin : g_flag
         assign fclr[i] = wr_flg & ~wb[i];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flags[i] <= mft_pkg::RST_FLAGS[i];
            end else if (fset[i]) begin
               flags[i] <= 1'b1;
            end else if (fclr[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // R7 combine select is plain storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags[mft_pkg::B_SEL] <= mft_pkg::RST_FLAGS[mft_pkg::B_SEL];
      end else if (wr_flg) begin
         flags[mft_pkg::B_SEL] <= wb[mft_pkg::B_SEL];
      end
   end

   // R14 capture0 dma enable cleared at block end
   // R16 compare0 dma enable cleared at block end
   // a software write in the same cycle re-arms the channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= mft_pkg::RST_MASK;
      end else if (wr_msk) begin
         mask <= wb;
      end else begin
         if (capture0_eob) begin
            mask[mft_pkg::B_CAP0_DMA] <= 1'b0;
         end
         if (compare0_eob) begin
            mask[mft_pkg::B_CMP0_DMA] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         obc <= mft_pkg::RST_OBC[7:1];
      end else if (wr_obc) begin
         obc <= wb[7:1];
      end
   end

   // R21 area select and high bits by software
   // R19 swap step flips bit2 on top of any write
   // R20 direction follows the channel last served
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr <= mft_pkg::RST_PTR;
      end else begin
         if (wr_ptr) begin
            ptr[7:3] <= wb[7:3];
            ptr[mft_pkg::B_AREA] <= wb[mft_pkg::B_AREA];
         end
         ptr[mft_pkg::B_PTR_TGL] <= (wr_ptr ? wb[mft_pkg::B_PTR_TGL] : ptr[mft_pkg::B_PTR_TGL]) ^ compare0_swap_step;
         if (compare0_dma_req) begin
            ptr[mft_pkg::B_DIR] <= 1'b1;
         end else if (capture0_dma_req) begin
            ptr[mft_pkg::B_DIR] <= 1'b0;
         end
      end
   end

   // ********************************************
   // dma requests and software capture strobes
   // ********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture0_dma_req <= 1'b0;
         compare0_dma_req <= 1'b0;
      end else begin
         capture0_dma_req <= capture0_evt & mask[mft_pkg::B_CAP0_DMA];
         compare0_dma_req <= compare0_evt & mask[mft_pkg::B_CMP0_DMA];
      end
   end

   // R5 soft load or capture strobe
   // R6 soft capture strobe, none in bicapture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_capture0_pulse <= 1'b0;
         sw_capture1_pulse <= 1'b0;
      end else begin
         sw_capture0_pulse <= sw_cap0;
         sw_capture1_pulse <= sw_cap1;
      end
   end

   // ********************************************
   // interrupts
   // ********************************************
   logic cap0_on, cap1_on, cap_req, cmp_req, ovf_req;

   // R15 mask gates plain or end-of-block request
   assign cap0_on = flags[mft_pkg::B_CAP0] & mask[mft_pkg::B_CAP0_IRQ];
   // R18 separate source masks
   assign cap1_on = flags[mft_pkg::B_CAP1] & mask[mft_pkg::B_CAP1_IRQ];
   // R7 or or and of capture sources
   assign cap_req = flags[mft_pkg::B_SEL] ? (cap0_on & cap1_on) : (cap0_on | cap1_on);
   // R8 compare0 with its mask
   // R9 compare1 with its mask
   assign cmp_req = (flags[mft_pkg::B_CMP0] & mask[mft_pkg::B_CMP0_IRQ])
      | (flags[mft_pkg::B_CMP1] & mask[mft_pkg::B_CMP1_IRQ]);
   // R10 overflow with its mask
   assign ovf_req = flags[mft_pkg::B_WRAP] & mask[mft_pkg::B_WRAP_IRQ];

   // R13 global gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_capture <= 1'b0;
         irq_compare <= 1'b0;
         irq_overflow <= 1'b0;
      end else begin
         irq_capture <= mask[mft_pkg::B_GIE] & cap_req;
         irq_compare <= mask[mft_pkg::B_GIE] & cmp_req;
         irq_overflow <= mask[mft_pkg::B_GIE] & ovf_req;
      end
   end

   // ********************************************
   // output b pin and on-chip event
   // ********************************************
   mft_ob_if ob ();

   assign ob.evt = {overflow_evt, compare1_evt, compare0_evt};
   assign ob.code = {obc[3:2], obc[5:4], obc[7:6]};

   mft_ob_merge mft_ob_merge_inst (.ob(ob.merge));

   // R4 preset write wins over events in that cycle
   // R1 apply merged action
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_output_b_pin <= mft_pkg::RST_OBC[mft_pkg::B_PRE];
      end else if (wr_obc) begin
         timer_output_b_pin <= wb[mft_pkg::B_PRE];
      end else if (ob.any) begin
         case (ob.merged)
            mft_pkg::ACT_SET: timer_output_b_pin <= 1'b1;
            mft_pkg::ACT_TGL: timer_output_b_pin <= ~timer_output_b_pin;
            mft_pkg::ACT_CLR: timer_output_b_pin <= 1'b0;
            default: timer_output_b_pin <= timer_output_b_pin;
         endcase
      end
   end

   // R3 one pulse per wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_chip_event <= 1'b0;
      end else begin
         on_chip_event <= overflow_evt & obc[mft_pkg::B_EVT_EN];
      end
   end

   // ********************************************
   // read path
   // ********************************************
   logic [7:0] rmux;

   // R4 preset bit reads back the pin
   always_comb begin
      rmux = 8'h00;
      if (hit_ptr) begin
         rmux = ptr;
      end else if (hit_obc) begin
         rmux = {obc, timer_output_b_pin};
      end else if (hit_flg) begin
         rmux = flags;
      end else if (hit_msk) begin
         rmux = mask;
      end
   end

   // read data is caught in the setup cycle and held for the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= {24'h0, rmux};
         pslverr <= ~hit_any;
      end
   end

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wrap;
      overflow_evt && obc[mft_pkg::B_EVT_EN];
   endsequence
   sequence s_one_pulse;
      on_chip_event ##1 (!on_chip_event || $past(overflow_evt));
   endsequence

   property p_ob_set;
      compare0_evt && !compare1_evt && !overflow_evt && !wr_obc
         && obc[7:6] == mft_pkg::ACT_SET |=> timer_output_b_pin;
   endproperty
   a_ob_set: assert property (p_ob_set) else $error("pin not set"); // R1
   property p_ob_merge;
      compare0_evt && compare1_evt && !overflow_evt && !wr_obc
         && obc[7:6] == mft_pkg::ACT_TGL && obc[5:4] == mft_pkg::ACT_CLR
         |=> timer_output_b_pin;
   endproperty
   a_ob_merge: assert property (p_ob_merge) else $error("merge wrong"); // R2
   property p_event;
      s_wrap |=> s_one_pulse;
   endproperty
   a_event: assert property (p_event) else $error("event pulse wrong"); // R3
   property p_no_event;
      !obc[mft_pkg::B_EVT_EN] && !wr_obc |=> !on_chip_event;
   endproperty
   a_no_event: assert property (p_no_event) else $error("stray event"); // R3
   property p_preset;
      wr_obc |=> timer_output_b_pin == $past(pwdata[0]);
   endproperty
   a_preset: assert property (p_preset) else $error("preset lost"); // R4
   property p_cap0_set;
      capture0_evt && !mask[mft_pkg::B_CAP0_DMA] |=> flags[mft_pkg::B_CAP0];
   endproperty
   a_cap0_set: assert property (p_cap0_set) else $error("capture0 flag lost"); // R22
   property p_cap1_sw;
      wr_flg && wb[mft_pkg::B_CAP1] && bicapture_mode |=> !sw_capture1_pulse;
   endproperty
   a_cap1_sw: assert property (p_cap1_sw) else $error("bicapture strobe"); // R6
   property p_gate;
      !mask[mft_pkg::B_GIE] |=> !irq_capture && !irq_compare && !irq_overflow;
   endproperty
   a_gate: assert property (p_gate) else $error("irq not gated"); // R13
   property p_cmp0_ovr;
      compare0_evt && flags[mft_pkg::B_CMP0] |=> flags[mft_pkg::B_CMP0_OVR];
   endproperty
   a_cmp0_ovr: assert property (p_cmp0_ovr) else $error("no overrun"); // R12
   property p_dma_clr;
      capture0_eob && !wr_msk |=> !mask[mft_pkg::B_CAP0_DMA];
   endproperty
   a_dma_clr: assert property (p_dma_clr) else $error("capture0 dma kept"); // R14
   property p_dir;
      compare0_dma_req |=> ptr[mft_pkg::B_DIR];
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong"); // R20
endmodule

//--- dv/mft_dma_model.sv
/*
 * mft_dma_model: stand-in for the dma controller serving the timer's
 * capture-0 and compare-0 channels.
 * assumes one-cycle request pulses on pclk; a block ends after BLOCK requests.
 */
`timescale 1ns/1ps
module mft_dma_model #(
   parameter int BLOCK = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic swap_en,
   input wire logic capture0_dma_req,
   input wire logic compare0_dma_req,
   output logic capture0_eob,
   output logic compare0_eob,
   output logic compare0_swap_step
);
   int cnt_cap;
   int cnt_cmp;

   // ********************************************
   // block counting
   // ********************************************
   // end of block reported
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_cap <= 0;
         cnt_cmp <= 0;
         capture0_eob <= 1'b0;
         compare0_eob <= 1'b0;
         compare0_swap_step <= 1'b0;
      end else begin
         capture0_eob <= capture0_dma_req && (cnt_cap == BLOCK - 1);
         compare0_eob <= compare0_dma_req && (cnt_cmp == BLOCK - 1);
         // swap steps only at a block end, so the pointer flips once a block
         compare0_swap_step <= swap_en && compare0_dma_req && (cnt_cmp == BLOCK - 1);
         if (capture0_dma_req) begin
            cnt_cap <= (cnt_cap == BLOCK - 1) ? 0 : cnt_cap + 1;
         end
         if (compare0_dma_req) begin
            cnt_cmp <= (cnt_cmp == BLOCK - 1) ? 0 : cnt_cmp + 1;
         end
      end
   end
endmodule

//--- dv/mft_flags_irq_dma_tb_top.sv
/*
 * mft_flags_irq_dma_tb_top: self-checking bench of the timer flag block.
 * assumes a zero-wait apb slave and one-cycle event pulses on pclk.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module mft_flags_irq_dma_tb_top;
   localparam logic [9:0] A_PTR = {mft_pkg::IDX_PTR, 2'h0};
   localparam logic [9:0] A_OBC = {mft_pkg::IDX_OBC, 2'h0};
   localparam logic [9:0] A_FLG = {mft_pkg::IDX_FLAGS, 2'h0};
   localparam logic [9:0] A_MSK = {mft_pkg::IDX_MASK, 2'h0};
   localparam logic [7:0] MB [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20};
   localparam logic [2:0] IQ [5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bicap, swap_en;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] evts;
   logic err, x;
   logic [1:0] swp, oce, dq;
   logic timer_output_b_pin, on_chip_event, sw0, sw1, cap_req, cmp_req;
   logic irq_capture, irq_compare, irq_overflow, cap_eob, cmp_eob, swap_step;
   int err_total, checked;

   mft_flags_irq_dma mft_flags_irq_dma_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture0_evt(evts[4]), .capture1_evt(evts[3]), .compare0_evt(evts[2]), .compare1_evt(evts[1]),
      .overflow_evt(evts[0]), .bicapture_mode(bicap), .capture0_eob(cap_eob), .compare0_eob(cmp_eob),
      .compare0_swap_step(swap_step), .timer_output_b_pin(timer_output_b_pin), .on_chip_event(on_chip_event),
      .sw_capture0_pulse(sw0), .sw_capture1_pulse(sw1), .capture0_dma_req(cap_req),
      .compare0_dma_req(cmp_req), .irq_capture(irq_capture), .irq_compare(irq_compare),
      .irq_overflow(irq_overflow));

   mft_dma_model mft_dma_model_inst (.pclk(pclk), .presetn(presetn), .swap_en(swap_en),
      .capture0_dma_req(cap_req), .compare0_dma_req(cmp_req), .capture0_eob(cap_eob),
      .compare0_eob(cmp_eob), .compare0_swap_step(swap_step));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ********************************************
   // access tasks
   // ********************************************
   task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1 swp = {sw0, sw1};
      @(posedge pclk);
   endtask

   task automatic reg_is(input logic [9:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask

   // one-cycle event; samples the pulses that answer it one cycle later
   task automatic ev(input logic [4:0] e);
      evts <= e;
      @(posedge pclk);
      evts <= 5'h00;
      #1 oce[1] = on_chip_event;
      dq = {cap_req, cmp_req};
      @(posedge pclk);
      #1 oce[0] = on_chip_event;
      @(posedge pclk);
   endtask

   task automatic results;
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      results();
   end

   // ********************************************
   // tests
   // ********************************************
   initial begin
      {presetn, psel, penable, pwrite, bicap, swap_en} = 6'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      evts = 5'h00;
      err_total = 0;
      checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reg_is(A_FLG, mft_pkg::RST_FLAGS);
      reg_is(A_MSK, mft_pkg::RST_MASK);
      apb(1'b0, 10'h004, 8'h00);
      `CHK({err, rd}, {1'b1, 32'h0})
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, A_OBC, {4'hf, c[1:0], 1'b0, p[0]});
            `CHK(timer_output_b_pin, p[0])
            ev(5'h01);
            x = (c == 0) ? 1'b1 : (c == 1) ? ~p[0] : (c == 2) ? 1'b0 : p[0];
            `CHK(timer_output_b_pin, x)
            reg_is(A_OBC, {4'hf, c[1:0], 1'b0, x});
         end
      end
      apb(1'b1, A_OBC, 8'h79);
      ev(5'h05);
      `CHK(timer_output_b_pin, 1'b1)
      apb(1'b1, A_OBC, 8'hb4);
      ev(5'h05);
      `CHK(timer_output_b_pin, 1'b1)
      // toggle on compare0 with clear on compare1 merges to set
      apb(1'b1, A_OBC, 8'h6c);
      ev(5'h06);
      `CHK(timer_output_b_pin, 1'b1)
      apb(1'b1, A_OBC, 8'h3c);
      ev(5'h04);
      `CHK(timer_output_b_pin, 1'b1)
      apb(1'b1, A_OBC, 8'hfe);
      ev(5'h01);
      `CHK(oce, 2'b10)
      apb(1'b1, A_OBC, 8'hfc);
      ev(5'h01);
      `CHK(oce, 2'b00)
      apb(1'b1, A_FLG, 8'h00);
      for (int g = 0; g < 2; g++) begin
         for (int i = 0; i < 5; i++) begin
            apb(1'b1, A_MSK, {g[0], 7'h0} | MB[i]);
            ev(5'h01 << i);
            reg_is(A_FLG, 8'h08 << i);
            `CHK({irq_capture, irq_compare, irq_overflow}, g[0] ? IQ[i] : 3'b000)
            apb(1'b1, A_FLG, 8'h00);
         end
      end
      reg_is(A_FLG, 8'h00);
      apb(1'b1, A_FLG, 8'h01);
      apb(1'b1, A_MSK, 8'hb0);
      ev(5'h10);
      `CHK(irq_capture, 1'b0)
      ev(5'h08);
      `CHK(irq_capture, 1'b1)
      apb(1'b1, A_FLG, 8'h00);
      ev(5'h14);
      ev(5'h14);
      reg_is(A_FLG, 8'ha6);
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b1, A_FLG, 8'h80);
      `CHK(swp, 2'b10)
      reg_is(A_FLG, 8'h84);
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b1, A_FLG, 8'h40);
      `CHK(swp, 2'b01)
      bicap <= 1'b1;
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b1, A_FLG, 8'h40);
      `CHK(swp, 2'b00)
      bicap <= 1'b0;
      apb(1'b1, A_FLG, 8'h00);
      // event lands on the very edge that takes the clearing write
      fork
         apb(1'b1, A_FLG, 8'h00);
         begin
            @(posedge pclk);
            evts <= 5'h01;
            @(posedge pclk);
            evts <= 5'h00;
         end
      join
      reg_is(A_FLG, 8'h08);
      apb(1'b1, A_FLG, 8'h00);
      apb(1'b1, A_PTR, 8'hf3);
      reg_is(A_PTR, 8'hf1);
      apb(1'b1, A_MSK, 8'he0);
      ev(5'h10);
      `CHK(dq, 2'b10)
      reg_is(A_FLG, 8'h00);
      ev(5'h10);
      reg_is(A_MSK, 8'ha0);
      reg_is(A_FLG, 8'h80);
      `CHK(irq_capture, 1'b1)
      apb(1'b1, A_FLG, 8'h00);
      swap_en <= 1'b1;
      apb(1'b1, A_MSK, 8'h8c);
      ev(5'h04);
      `CHK(dq, 2'b01)
      ev(5'h04);
      reg_is(A_MSK, 8'h84);
      reg_is(A_FLG, 8'h20);
      `CHK(irq_compare, 1'b1)
      reg_is(A_PTR, 8'hf7);
      results();
   end
endmodule
